// >>> pkg/cam_pkg.sv
// constants, types and decode helpers for capability authorized memory access
package cam_pkg;

	// ***********************************************************
	// widths and field positions
	// ***********************************************************
	localparam int CAM_XLEN = 32;
	localparam int CAM_CAP_WIDTH = 64;
	localparam int CAM_CAP_BYTES = CAM_CAP_WIDTH / 8;
	localparam int CAM_GRAN_LSB = 3;
	localparam int CAM_MANT_W = 8;
	localparam int CAM_PERM_R = 0;
	localparam int CAM_PERM_W = 1;
	localparam int CAM_PERM_C = 2;
	localparam int CAM_PERM_LM = 3;
	localparam int CAM_PERM_X = 4;
	localparam logic [3:0] CAM_EXP_MAX = 4'he;
	localparam logic [3:0] CAM_CT_UNSEALED = 4'h0;
	localparam logic [2:0] CAM_RSVD_OK = 3'h0;
	localparam logic [4:0] CAM_REG_ZERO = 5'h00;
	localparam logic [31:0] CAM_LINK_STEP = 32'h0000_0004;
	localparam logic [31:0] CAM_PC_LSB_MASK = 32'hffff_fffe;
	localparam logic [1:0] CAM_SIZE_CAP = 2'h3;
	localparam logic [32:0] CAM_ADDR_LIMIT = 33'h1_0000_0000;
	localparam int CAM_AUIPC_SHIFT_DEF = 12;
	localparam int CAM_AUIPC_SHIFT_MAX = 12;

	// ***********************************************************
	// types
	// ***********************************************************
	typedef struct packed {
		logic [7:0] t_mant;
		logic [7:0] b_mant;
		logic [3:0] exp;
		logic [3:0] ctype;
		logic [2:0] rsvd;
		logic [4:0] perms;
	} cam_meta_t;

	typedef struct packed {
		logic tag;
		cam_meta_t meta;
		logic [31:0] addr;
	} cam_cap_t;

	typedef enum logic [3:0] {
		CAM_OP_NONE, CAM_OP_CAP_STORE, CAM_OP_STORE, CAM_OP_LOAD,
		CAM_OP_AUIPC, CAM_OP_JALR, CAM_OP_JUMP, CAM_OP_CAP_ADD,
		CAM_OP_INT_WB
	} cam_op_t;

	typedef enum logic [1:0] {
		CAM_PMA_TAGGED, CAM_PMA_TAG_STRIP, CAM_PMA_TAG_FAULT
	} cam_pma_t;

	typedef enum logic [2:0] {
		CAM_FLT_NONE, CAM_FLT_TAG, CAM_FLT_SEAL, CAM_FLT_PERM,
		CAM_FLT_ADDR, CAM_FLT_LENGTH, CAM_FLT_ALIGN, CAM_FLT_PMA
	} cam_fault_t;

	typedef struct packed {
		cam_op_t op;
		logic [4:0] base_idx;
		cam_cap_t base_cap;
		logic [31:0] offset;
		cam_cap_t src_cap;
		logic [1:0] size;
		cam_pma_t pma;
	} cam_req_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0] size;
		logic is_unsigned;
	} cam_ld_rsp_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [63:0] data;
		logic [1:0] size;
		logic cap_write;
		logic tag_val;
		logic [1:0] tag_mask;
	} cam_mem_wr_t;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [1:0] size;
	} cam_mem_rd_t;

	typedef struct packed {
		logic valid;
		cam_cap_t cap;
	} cam_wb_t;

	typedef struct packed {
		logic ok;
		logic [32:0] base;
		logic [32:0] top;
	} cam_bnd_t;

	// ***********************************************************
	// decode helpers
	// ***********************************************************
	// bounds sit in the aligned region of 2^(exp+8) around the address
	function automatic cam_bnd_t cam_bounds(input cam_cap_t c);
		cam_bnd_t b;
		logic [4:0] sh;
		logic [32:0] upper;
		sh = 5'(c.meta.exp) + 5'(CAM_MANT_W);
		upper = {1'b0, (c.addr >> sh) << sh};
		b.base = upper + ({25'h0, c.meta.b_mant} << c.meta.exp);
		b.top = upper + ({25'h0, c.meta.t_mant} << c.meta.exp);
		b.ok = (c.meta.exp <= CAM_EXP_MAX) &&
			(c.meta.t_mant >= c.meta.b_mant);
		return b;
	endfunction

	function automatic logic cam_sealed(input cam_cap_t c);
		return c.meta.ctype != CAM_CT_UNSEALED;
	endfunction

endpackage

// >>> verilog/cam_addr_set.sv
// checked address set: moves a capability to a new address
`timescale 1ns/100ps
module cam_addr_set
	import cam_pkg::*;
(
	input cam_cap_t cap_in,
	input logic [31:0] new_addr,
	output cam_cap_t cap_out,
	output logic exact
);

	// ***********************************************************
	// representability
	// ***********************************************************
	cam_bnd_t bnd;
	logic [4:0] sh;
	logic moved;

	// the new address must keep the region of the old one
	assign bnd = cam_bounds(cap_in);
	assign sh = 5'(cap_in.meta.exp) + 5'(CAM_MANT_W);
	assign moved = new_addr != cap_in.addr;
	assign exact = bnd.ok && ((new_addr >> sh) == (cap_in.addr >> sh));

	// ***********************************************************
	// result
	// ***********************************************************
	// a sealed capability keeps its tag only if its address stays put
	always_comb begin
		cap_out = cap_in;
		cap_out.addr = new_addr;
		cap_out.tag = cap_in.tag && exact &&
			!(cam_sealed(cap_in) && moved);
	end

endmodule

// >>> verilog/cam_core.sv
// capability checks for loads, stores, pc updates and address results
//
`timescale 1ns/100ps
module cam_core
	import cam_pkg::*;
#(
	parameter int AUIPC_SHIFT = CAM_AUIPC_SHIFT_DEF
)
(
	input logic sys_clk,
	input logic rst,
	input logic req_valid,
	input cam_req_t req,
	input cam_cap_t pc_cap,
	input logic ld_rsp_valid,
	input cam_ld_rsp_t ld_rsp,
	output cam_mem_wr_t mem_wr,
	output cam_mem_rd_t mem_rd,
	output cam_fault_t fault,
	output logic [31:0] fault_addr,
	output cam_wb_t wb,
	output cam_wb_t pc_upd,
	output cam_wb_t ld_wb,
	output logic retire_ok,
	output logic retire_fail
);

	// ***********************************************************
	// elaboration checks
	// ***********************************************************
	// a wider shift would push immediate bits out of the offset
	generate
		if (AUIPC_SHIFT < 0 || AUIPC_SHIFT > CAM_AUIPC_SHIFT_MAX) begin : g_chk
			$error("cam_core: AUIPC_SHIFT out of range");
		end
	endgenerate

	// ***********************************************************
	// request decode
	// ***********************************************************
	logic is_cap_store;
	logic is_store;
	logic is_load;
	logic is_mem;
	logic [1:0] acc_size;
	logic [32:0] acc_bytes;
	logic [31:0] eff_addr;
	logic [32:0] end_addr;
	logic [32:0] last_byte;
	cam_bnd_t bnd;

	assign is_cap_store = req_valid && req.op == CAM_OP_CAP_STORE;
	assign is_store = req_valid && req.op == CAM_OP_STORE;
	assign is_load = req_valid && req.op == CAM_OP_LOAD;
	assign is_mem = is_cap_store || is_store || is_load;

	// capability stores always move one full capability
	assign acc_size = is_cap_store ? CAM_SIZE_CAP : req.size;
	assign acc_bytes = 33'h1 << acc_size;

	// base address comes from the full capability register
	assign eff_addr = req.base_cap.addr + req.offset;
	assign end_addr = {1'b0, eff_addr} + acc_bytes;
	assign last_byte = end_addr - 33'h1;
	assign bnd = cam_bounds(req.base_cap);

	// ***********************************************************
	// authorization checks
	// ***********************************************************
	logic auth_valid;
	logic auth_sealed;
	logic perm_ok;
	logic range_ok;
	logic in_bounds;
	logic aligned;
	logic stored_tag;
	logic pma_fault;
	cam_fault_t nxt_fault;

	// register zero holds the null capability and never authorizes
	assign auth_valid = req.base_cap.tag &&
		req.base_cap.meta.rsvd == CAM_RSVD_OK &&
		req.base_idx != CAM_REG_ZERO;
	assign auth_sealed = cam_sealed(req.base_cap);
	assign perm_ok = is_load ? req.base_cap.meta.perms[CAM_PERM_R] :
		req.base_cap.meta.perms[CAM_PERM_W];
	assign range_ok = end_addr <= CAM_ADDR_LIMIT;
	// undecodable bounds count as out of bounds
	assign in_bounds = bnd.ok && bnd.base <= {1'b0, eff_addr} &&
		end_addr <= bnd.top;
	assign aligned = !is_cap_store ||
		eff_addr[CAM_GRAN_LSB-1:0] == '0;

	// stored tag survives only with a tagged source, transfer right and
	// a region that keeps tags
	assign stored_tag = is_cap_store && req.src_cap.tag &&
		req.base_cap.meta.perms[CAM_PERM_C] &&
		req.pma != CAM_PMA_TAG_STRIP;
	assign pma_fault = stored_tag && req.pma == CAM_PMA_TAG_FAULT;

	// first failing check wins; translation only sees clean requests
	always_comb begin
		nxt_fault = CAM_FLT_NONE;
		if (is_mem) begin
			if (!auth_valid) begin
				nxt_fault = CAM_FLT_TAG;
			end else if (auth_sealed) begin
				nxt_fault = CAM_FLT_SEAL;
			end else if (!perm_ok) begin
				nxt_fault = CAM_FLT_PERM;
			end else if (!range_ok) begin
				nxt_fault = CAM_FLT_ADDR;
			end else if (!in_bounds) begin
				nxt_fault = CAM_FLT_LENGTH;
			end else if (!aligned) begin
				nxt_fault = CAM_FLT_ALIGN;
			end else if (pma_fault) begin
				nxt_fault = CAM_FLT_PMA;
			end
		end
	end

	// ***********************************************************
	// address results through the checked address set
	// ***********************************************************
	cam_cap_t set_a_in;
	logic [31:0] set_a_addr;
	cam_cap_t set_a_out;
	cam_cap_t set_b_out;
	cam_cap_t link_out;
	logic [31:0] auipc_off;
	logic set_a_exact;

	// immediate sign-extended and shifted into a 32-bit offset
	assign auipc_off = {{12{req.offset[19]}}, req.offset[19:0]}
		<< AUIPC_SHIFT;

	// one shared adder path; the op picks which capability moves
	always_comb begin
		set_a_in = req.base_cap;
		set_a_addr = eff_addr;
		unique case (req.op)
			CAM_OP_AUIPC: begin
				set_a_in = pc_cap;
				set_a_addr = pc_cap.addr + auipc_off;
			end
			CAM_OP_JUMP: begin
				set_a_in = pc_cap;
				set_a_addr = pc_cap.addr + req.offset;
			end
			CAM_OP_NONE, CAM_OP_CAP_STORE, CAM_OP_STORE, CAM_OP_LOAD,
			CAM_OP_JALR, CAM_OP_CAP_ADD, CAM_OP_INT_WB: begin
				set_a_in = req.base_cap;
				set_a_addr = eff_addr;
			end
		endcase
	end

	cam_addr_set u_set_a (
		.cap_in(set_a_in),
		.new_addr(set_a_addr),
		.cap_out(set_a_out),
		.exact(set_a_exact)
	);

	// second step of an indirect jump drops address bit zero
	cam_addr_set u_set_b (
		.cap_in(set_a_out),
		.new_addr(set_a_out.addr & CAM_PC_LSB_MASK),
		.cap_out(set_b_out),
		.exact()
	);

	// link value is the next instruction, also a checked move
	cam_addr_set u_set_link (
		.cap_in(pc_cap),
		.new_addr(pc_cap.addr + CAM_LINK_STEP),
		.cap_out(link_out),
		.exact()
	);

	// ***********************************************************
	// memory write request
	// ***********************************************************
	logic wr_ok;
	logic two_gran;

	assign wr_ok = (is_cap_store || is_store) && nxt_fault == CAM_FLT_NONE;
	// a misaligned ordinary store may straddle two tag granules
	assign two_gran = last_byte[31:CAM_GRAN_LSB] !=
		eff_addr[31:CAM_GRAN_LSB];

	// faulting stores never reach memory or the tag store
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mem_wr <= '0;
		end else begin
			mem_wr.valid <= wr_ok;
			mem_wr.addr <= eff_addr;
			mem_wr.size <= acc_size;
			if (is_cap_store) begin
				mem_wr.data <= {req.src_cap.meta, req.src_cap.addr};
				mem_wr.cap_write <= stored_tag;
				mem_wr.tag_val <= stored_tag;
				mem_wr.tag_mask <= {1'b0, wr_ok};
			end else begin
				mem_wr.data <= {32'h0, req.src_cap.addr};
				mem_wr.cap_write <= 1'b0;
				mem_wr.tag_val <= 1'b0;
				mem_wr.tag_mask <= {wr_ok && two_gran, wr_ok};
			end
		end
	end

	// ***********************************************************
	// memory read request
	// ***********************************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mem_rd <= '0;
		end else begin
			mem_rd.valid <= is_load && nxt_fault == CAM_FLT_NONE;
			mem_rd.addr <= eff_addr;
			mem_rd.size <= acc_size;
		end
	end

	// ***********************************************************
	// fault and retire
	// ***********************************************************
	// every valid op but CAM_OP_NONE retires one way or the other, one cycle later
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fault <= CAM_FLT_NONE;
			fault_addr <= '0;
			retire_ok <= 1'b0;
			retire_fail <= 1'b0;
		end else begin
			fault <= nxt_fault;
			fault_addr <= eff_addr;
			retire_ok <= req_valid && req.op != CAM_OP_NONE &&
				nxt_fault == CAM_FLT_NONE;
			retire_fail <= nxt_fault != CAM_FLT_NONE;
		end
	end

	// ***********************************************************
	// register write back
	// ***********************************************************
	// integer results carry no metadata; address results are whole caps
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wb <= '0;
		end else begin
			wb.valid <= 1'b0;
			wb.cap <= '0;
			if (req_valid) begin
				unique case (req.op)
					CAM_OP_AUIPC, CAM_OP_CAP_ADD: begin
						wb.valid <= 1'b1;
						// tag already dropped when inexact
						wb.cap <= set_a_out;
					end
					CAM_OP_JALR, CAM_OP_JUMP: begin
						wb.valid <= 1'b1;
						wb.cap <= link_out;
					end
					CAM_OP_INT_WB: begin
						wb.valid <= 1'b1;
						wb.cap.addr <= req.src_cap.addr;
					end
					CAM_OP_NONE, CAM_OP_CAP_STORE, CAM_OP_STORE,
					CAM_OP_LOAD: begin
						wb.valid <= 1'b0;
					end
				endcase
			end
		end
	end

	// ***********************************************************
	// program counter update
	// ***********************************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pc_upd <= '0;
		end else begin
			pc_upd.valid <= req_valid &&
				(req.op == CAM_OP_JALR || req.op == CAM_OP_JUMP);
			if (req.op == CAM_OP_JALR) begin
				pc_upd.cap <= set_b_out;
			end else begin
				pc_upd.cap <= set_a_out;
			end
		end
	end

	// ***********************************************************
	// ordinary load results
	// ***********************************************************
	// narrow the returned word like a plain integer load
	function automatic logic [31:0] cam_ld_ext(input cam_ld_rsp_t r);
		logic [31:0] v;
		v = r.data;
		unique case (r.size)
			2'h0: v = {{24{r.data[7] & !r.is_unsigned}}, r.data[7:0]};
			2'h1: v = {{16{r.data[15] & !r.is_unsigned}}, r.data[15:0]};
			2'h2, 2'h3: v = r.data;
		endcase
		return v;
	endfunction

	// load results never carry a tag or metadata
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ld_wb <= '0;
		end else begin
			ld_wb.valid <= ld_rsp_valid;
			ld_wb.cap.tag <= 1'b0;
			ld_wb.cap.meta <= '0;
			ld_wb.cap.addr <= cam_ld_ext(ld_rsp);
		end
	end

endmodule

// >>> verif/cam_core_asserts.sv
// port assertions for the capability access core
`timescale 1ns/100ps
module cam_core_asserts
	import cam_pkg::*;
#(
	parameter int AUIPC_SHIFT = CAM_AUIPC_SHIFT_DEF
)
(
	input logic sys_clk,
	input logic rst,
	input logic req_valid,
	input cam_req_t req,
	input cam_cap_t pc_cap,
	input logic ld_rsp_valid,
	input cam_ld_rsp_t ld_rsp,
	input cam_mem_wr_t mem_wr,
	input cam_mem_rd_t mem_rd,
	input cam_fault_t fault,
	input cam_wb_t wb,
	input cam_wb_t ld_wb,
	input logic retire_ok,
	input logic retire_fail
);
	logic mem_op;
	logic cst;
	logic [31:0] eff;

	// ****
	// request decode
	// ****
	assign mem_op = req_valid && (req.op == CAM_OP_STORE ||
		req.op == CAM_OP_CAP_STORE || req.op == CAM_OP_LOAD);
	assign cst = req_valid && req.op == CAM_OP_CAP_STORE;
	assign eff = req.base_cap.addr + req.offset;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ****
	// checks
	// ****
	AST_FAULT_QUIET: assert property (
		fault != CAM_FLT_NONE |-> !mem_wr.valid && !mem_rd.valid &&
		retire_fail && !retire_ok) else $error("faulting access went out");
	AST_BASE_TAG: assert property (
		mem_op && (!req.base_cap.tag || req.base_idx == CAM_REG_ZERO)
		|=> fault == CAM_FLT_TAG) else $error("untagged base not refused");
	AST_INTEGRITY: assert property (
		mem_op && req.base_cap.meta.rsvd != CAM_RSVD_OK
		|=> fault == CAM_FLT_TAG) else $error("bad reserved bits let by");
	AST_SEAL_ORDER: assert property (
		mem_op && req.base_cap.tag && req.base_idx != CAM_REG_ZERO &&
		req.base_cap.meta.rsvd == CAM_RSVD_OK &&
		req.base_cap.meta.ctype != CAM_CT_UNSEALED
		|=> fault == CAM_FLT_SEAL) else $error("sealed base wrong cause");
	AST_CAP_ALIGN: assert property (
		cst && eff[2:0] != 3'h0 |=> fault != CAM_FLT_NONE && !mem_wr.valid)
		else $error("misaligned capability store written");
	AST_NO_TRANSFER: assert property (
		cst && (!req.base_cap.meta.perms[CAM_PERM_C] || !req.src_cap.tag ||
		req.pma == CAM_PMA_TAG_STRIP)
		|=> !mem_wr.tag_val && !mem_wr.cap_write) else $error("tag kept");
	AST_WRITE_KIND: assert property (
		mem_wr.valid |-> mem_wr.cap_write == mem_wr.tag_val)
		else $error("write kind does not follow stored tag");
	AST_PLAIN_SPAN: assert property (
		req_valid && req.op == CAM_OP_STORE &&
		4'(eff[2:0]) + (4'h1 << req.size) > 4'h8
		|=> fault != CAM_FLT_NONE ||
		(mem_wr.tag_mask == 2'h3 && !mem_wr.tag_val))
		else $error("straddling store cleared one tag only");
	AST_LOAD_META: assert property (
		ld_rsp_valid && ld_rsp.size == 2'h2 |=> ld_wb.valid &&
		ld_wb.cap == cam_cap_t'({33'h0, $past(ld_rsp.data)}))
		else $error("word load result wrong");
	AST_AUIPC_ADDR: assert property (
		req_valid && req.op == CAM_OP_AUIPC |=> wb.valid &&
		wb.cap.addr == $past(pc_cap.addr) +
		({{12{$past(req.offset[19])}}, $past(req.offset[19:0])}
		<< AUIPC_SHIFT))
		else $error("upper immediate address wrong");
	AST_INT_RESULT: assert property (
		req_valid && req.op == CAM_OP_INT_WB |=> wb.valid && !wb.cap.tag &&
		wb.cap.meta == '0) else $error("integer result kept metadata");
endmodule

bind cam_core cam_core_asserts #(.AUIPC_SHIFT(AUIPC_SHIFT)) u_chk (
	.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
	.pc_cap(pc_cap), .ld_rsp_valid(ld_rsp_valid), .ld_rsp(ld_rsp),
	.mem_wr(mem_wr), .mem_rd(mem_rd), .fault(fault), .wb(wb),
	.ld_wb(ld_wb), .retire_ok(retire_ok), .retire_fail(retire_fail));

// >>> verif/cam_mem_model.sv
// memory model returning load data to the capability access core
`timescale 1ns/100ps
module cam_mem_model
	import cam_pkg::*;
(
	input logic sys_clk,
	input logic rst,
	input cam_mem_rd_t mem_rd,
	input logic slow,
	input logic uns,
	output logic ld_rsp_valid,
	output cam_ld_rsp_t ld_rsp
);
	cam_mem_rd_t pend[$];
	logic pu[$];
	int wait_cnt;
	logic [7:0] a;
	logic uns_d;

	// the unsigned hint trails the request by one edge, as mem_rd does
	always @(posedge sys_clk) begin
		uns_d <= uns;
	end

	initial begin
		ld_rsp_valid = 1'b0;
		ld_rsp = '0;
		wait_cnt = 0;
	end

	// ****
	// reads queue up; answers come promptly or after a stall
	// ****
	always @(posedge sys_clk) begin
		if (mem_rd.valid) begin
			pend.push_back(mem_rd);
			pu.push_back(uns_d);
		end
		if (rst || wait_cnt > 0 || pend.size() == 0) begin
			ld_rsp_valid <= 1'b0;
			ld_rsp.data <= ~ld_rsp.data; // idle data never holds still
			wait_cnt <= (wait_cnt > 0) ? wait_cnt - 1 : 0;
		end else begin
			a = pend[0].addr[7:0];
			ld_rsp_valid <= 1'b1;
			ld_rsp.size <= pend[0].size;
			ld_rsp.is_unsigned <= pu.pop_front();
			ld_rsp.data <= pend[0].size == 2'h0 ? {24'h0, a} :
				pend[0].size == 2'h1 ? {16'h0, a, a} : {a, a, a, a};
			void'(pend.pop_front());
			wait_cnt <= slow ? 3 : 0;
		end
	end
endmodule

// >>> verif/testbench.sv
// self-checking bench for the capability access core
`timescale 1ns/100ps
module testbench;
	import cam_pkg::*;
	logic sys_clk, rst, req_valid, ld_rsp_valid, retire_ok, retire_fail;
	logic slow, uns;
	logic [4:0] idx;
	logic [31:0] fault_addr, o;
	cam_req_t req;
	cam_cap_t pc_cap, bc, sc, t;
	cam_ld_rsp_t ld_rsp;
	cam_mem_wr_t mem_wr;
	cam_mem_rd_t mem_rd;
	cam_fault_t fault;
	cam_wb_t wb, pc_upd, ld_wb;
	int fail_count, n_tests, seed;
	cam_mem_wr_t q_wr[$];
	logic [35:0] q_flt[$];
	cam_cap_t q_wb[$], q_pc[$], q_ld[$];

	cam_core u_dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
		.req(req), .pc_cap(pc_cap), .ld_rsp_valid(ld_rsp_valid),
		.ld_rsp(ld_rsp), .mem_wr(mem_wr), .mem_rd(mem_rd), .fault(fault),
		.fault_addr(fault_addr), .wb(wb), .pc_upd(pc_upd), .ld_wb(ld_wb),
		.retire_ok(retire_ok), .retire_fail(retire_fail));
	cam_mem_model u_mem (.sys_clk(sys_clk), .rst(rst), .mem_rd(mem_rd),
		.slow(slow), .uns(uns), .ld_rsp_valid(ld_rsp_valid), .ld_rsp(ld_rsp));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ****
	// helpers
	// ****
	function automatic cam_cap_t mk(logic [4:0] p, logic [31:0] a);
		mk = '0;
		mk.tag = 1'b1;
		mk.meta.t_mant = 8'hff; // exp 0 keeps the region 256 bytes
		mk.meta.perms = p;
		mk.addr = a;
	endfunction
	// only valid for unsealed exp 0 caps, the only kind used here
	function automatic cam_cap_t setx(cam_cap_t c, logic [31:0] n);
		setx = c;
		setx.addr = n;
		if (n[31:8] != c.addr[31:8])
			setx.tag = 1'b0;
	endfunction
	task automatic rep(logic [127:0] g, logic [127:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic cmp_wr(cam_mem_wr_t g, cam_mem_wr_t e);
		rep(128'(g), 128'(e));
	endtask
	task automatic cmp_cap(cam_cap_t g, cam_cap_t e);
		rep(128'(g), 128'(e));
	endtask
	task automatic cmp_flt(logic [35:0] g, logic [35:0] e);
		rep(128'(g), 128'(e));
	endtask
	task automatic send(cam_op_t op, cam_cap_t b, logic [31:0] off,
		cam_cap_t s, logic [1:0] sz, cam_pma_t pm);
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req <= '{op: op, base_idx: idx, base_cap: b, offset: off,
			src_cap: s, size: sz, pma: pm};
	endtask
	task automatic cst(cam_cap_t b, logic [31:0] off, cam_cap_t s,
		cam_pma_t pm, cam_fault_t f, logic tv);
		logic [31:0] e;
		e = b.addr + off;
		if (f == CAM_FLT_NONE)
			q_wr.push_back('{1'b1, e, {s.meta, s.addr}, CAM_SIZE_CAP, tv, tv,
				2'h1});
		else
			q_flt.push_back({f, e, 1'b1});
		send(CAM_OP_CAP_STORE, b, off, s, CAM_SIZE_CAP, pm);
	endtask
	task automatic pst(logic [31:0] off, logic [1:0] sz, logic [1:0] m);
		q_wr.push_back('{1'b1, bc.addr + off, {32'h0, sc.addr}, sz, 1'b0,
			1'b0, m});
		send(CAM_OP_STORE, bc, off, sc, sz, CAM_PMA_TAGGED);
	endtask
	task automatic ld(logic [31:0] off, logic [1:0] sz, logic u);
		logic [7:0] a;
		logic [31:0] d;
		a = 8'(bc.addr + off);
		case (sz)
			2'h0: d = u ? {24'h0, a} : {{24{a[7]}}, a};
			2'h1: d = u ? {16'h0, a, a} : {{16{a[7]}}, a, a};
			default: d = {a, a, a, a};
		endcase
		q_ld.push_back(cam_cap_t'({33'h0, d}));
		send(CAM_OP_LOAD, bc, off, sc, sz, CAM_PMA_TAGGED);
		// set with the request so the model pairs it with that read
		uns <= u;
	endtask
	task automatic close_out();
		$display("mismatches=%0d comparisons=%0d", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ****
	// result monitor, sampled mid-cycle when outputs are settled
	// ****
	always @(negedge sys_clk) begin
		if (!rst && mem_wr.valid) begin
			cmp_wr(mem_wr, q_wr.size() ? q_wr.pop_front() : '0);
			rep({retire_ok, retire_fail}, 2'h2);
		end
		if (!rst && fault != CAM_FLT_NONE)
			cmp_flt({fault, fault_addr, retire_fail},
				q_flt.size() ? q_flt.pop_front() : '0);
		if (!rst && mem_rd.valid)
			rep({retire_ok, retire_fail}, 2'h2);
		if (!rst && wb.valid) begin
			cmp_cap(wb.cap, q_wb.size() ? q_wb.pop_front() : '0);
			rep({retire_ok, retire_fail}, 2'h2);
		end
		if (!rst && pc_upd.valid)
			cmp_cap(pc_upd.cap, q_pc.size() ? q_pc.pop_front() : '0);
		if (!rst && ld_wb.valid)
			cmp_cap(ld_wb.cap, q_ld.size() ? q_ld.pop_front() : '0);
	end

	// ****
	// main sequence
	// ****
	initial begin
		seed = 40;
		fail_count = 0;
		n_tests = 0;
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		slow = 1'b0;
		uns = 1'b0;
		idx = 5'h01;
		pc_cap = mk(5'h10, 32'h0000_1000);
		bc = mk(5'h07, 32'h0000_1000);
		sc = mk(5'h03, 32'h0000_00a5);
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		// capability stores, back to back
		cst(bc, 32'h8, sc, CAM_PMA_TAGGED, CAM_FLT_NONE, 1'b1);
		cst(mk(5'h03, 32'h1000), 32'h8, sc, CAM_PMA_TAGGED, CAM_FLT_NONE,
			1'b0);
		t = sc;
		t.tag = 1'b0;
		cst(bc, 32'h10, t, CAM_PMA_TAG_FAULT, CAM_FLT_NONE, 1'b0);
		cst(bc, 32'h18, sc, CAM_PMA_TAG_STRIP, CAM_FLT_NONE, 1'b0);
		cst(bc, 32'h18, sc, CAM_PMA_TAG_FAULT, CAM_FLT_PMA, 1'b0);
		cst(bc, 32'h1c, sc, CAM_PMA_TAG_FAULT, CAM_FLT_ALIGN, 1'b0);
		cst(bc, 32'hfc, sc, CAM_PMA_TAGGED, CAM_FLT_LENGTH, 1'b0);
		t = bc;
		t.meta.b_mant = 8'hff;
		t.meta.t_mant = 8'h00;
		cst(t, 32'h8, sc, CAM_PMA_TAGGED, CAM_FLT_LENGTH, 1'b0);
		cst(mk(5'h07, 32'hffff_fffc), 32'h0, sc, CAM_PMA_TAGGED,
			CAM_FLT_ADDR, 1'b0);
		cst(mk(5'h05, 32'h1000), 32'h4, sc, CAM_PMA_TAGGED, CAM_FLT_PERM,
			1'b0);
		t = mk(5'h05, 32'h1000);
		t.meta.ctype = 4'h1;
		cst(t, 32'h8, sc, CAM_PMA_TAGGED, CAM_FLT_SEAL, 1'b0);
		t.meta.rsvd = 3'h1;
		cst(t, 32'h8, sc, CAM_PMA_TAGGED, CAM_FLT_TAG, 1'b0);
		t.meta.rsvd = 3'h0;
		t.tag = 1'b0;
		cst(t, 32'h8, sc, CAM_PMA_TAGGED, CAM_FLT_TAG, 1'b0);
		idx = 5'h00;
		cst(bc, 32'h8, sc, CAM_PMA_TAGGED, CAM_FLT_TAG, 1'b0);
		idx = 5'h01;
		// ordinary stores, straddling and not
		pst(32'h6, 2'h2, 2'h3);
		pst(32'h7, 2'h1, 2'h3);
		pst(32'h4, 2'h2, 2'h1);
		pst(32'h0, 2'h0, 2'h1);
		// loads, memory prompt then stalling
		for (int i = 0; i < 2; i++) begin
			slow <= 1'(i);
			ld(32'h84, 2'h2, 1'b0);
			ld(32'h90, 2'h0, 1'b0);
			ld(32'h90, 2'h0, 1'b1);
			ld(32'ha2, 2'h1, 1'b0);
			ld(32'ha2, 2'h1, 1'b1);
		end
		q_flt.push_back({CAM_FLT_PERM, 32'h0000_1040, 1'b1});
		send(CAM_OP_LOAD, mk(5'h02, 32'h1000), 32'h40, sc, 2'h2,
			CAM_PMA_TAGGED);
		// address results and pc changes
		for (int i = 0; i < 2; i++) begin
			q_wb.push_back(setx(pc_cap, pc_cap.addr + (32'(i) << 12)));
			send(CAM_OP_AUIPC, bc, 32'(i), sc, 2'h0, CAM_PMA_TAGGED);
		end
		q_pc.push_back(setx(bc, 32'h0000_1020));
		q_wb.push_back(setx(pc_cap, pc_cap.addr + CAM_LINK_STEP));
		send(CAM_OP_JALR, bc, 32'h21, sc, 2'h0, CAM_PMA_TAGGED);
		q_pc.push_back(setx(pc_cap, pc_cap.addr + 32'h200));
		q_wb.push_back(setx(pc_cap, pc_cap.addr + CAM_LINK_STEP));
		send(CAM_OP_JUMP, bc, 32'h200, sc, 2'h0, CAM_PMA_TAGGED);
		q_wb.push_back(cam_cap_t'({33'h0, sc.addr}));
		send(CAM_OP_INT_WB, bc, 32'h0, sc, 2'h0, CAM_PMA_TAGGED);
		repeat (20) begin
			o = $random(seed) & 32'h1ff;
			q_wb.push_back(setx(bc, bc.addr + o));
			send(CAM_OP_CAP_ADD, bc, o, sc, 2'h0, CAM_PMA_TAGGED);
		end
		@(posedge sys_clk);
		req_valid <= 1'b0;
		// drain, bounded
		for (int i = 0; i < 50 && (q_wr.size() + q_flt.size() + q_wb.size() +
			q_pc.size() + q_ld.size()) > 0; i++)
			@(posedge sys_clk);
		if (q_wr.size() + q_flt.size() + q_wb.size() + q_pc.size() +
			q_ld.size() > 0)
			fail_count++;
		close_out();
	end
endmodule
